// file: hw/cls_scan_regs.svh
/*
 * Constants of the cascaded line-sensor scan block: pixel counts, scan
 * timing in clock cycles and sample widths.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef CLS_SCAN_REGS_SVH
`define CLS_SCAN_REGS_SVH

// Array geometry
`define CLS_PIXELS        344
`define CLS_SAMPLE_BITS   8
`define CLS_IDX_BITS      9

// Scan timing, in clock cycles
`define CLS_TICK_BITS     8
`define CLS_INIT_CYCLES   8'h52
`define CLS_CHAIN_LEAD    8'h0a
`define CLS_EOS_LEAD      9'h00a

// Clock and the pixel-rate ceiling; no logic enforces the ceiling, one pixel goes out per clock
`define CLS_CLOCK_KHZ     250000
`define CLS_MAX_RATE_KHZ  4000

// Check timing of a self-starting die, cycles since global start
`define CLS_AGE_BITS        10
`define CLS_FIRST_CYCLE     10'h053
`define CLS_EOS_CYCLE       10'h1a0
`define CLS_LAST_CYCLE      10'h1aa
`define CLS_EOS_CYCLE_HALF  10'h0f4
`define CLS_LAST_CYCLE_HALF 10'h0fe

`endif

// file: hw/cls_pkg.sv
/*
 * Types shared by the cascaded line-sensor scan block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cls_pkg;

    // Scan sequencer states
    typedef enum logic [1:0] {
        CLS_IDLE = 2'b00,
        CLS_INIT = 2'b01,
        CLS_WAIT = 2'b10,
        CLS_READ = 2'b11
    } cls_state_e;

endpackage

// file: hw/cls_pixel_hold.sv
/*
 * Per-pixel integrate-and-hold store: every active pixel integrates its light
 * level each cycle; a transfer copies all integrators into hold cells and
 * restarts integration, so the held line can be read out meanwhile.
 * Assumes photo levels are synchronous to the clock.
 */
`include "cls_scan_regs.svh"

module cls_pixel_hold
    import cls_pkg::*;
#(
    parameter int PIXELS = `CLS_PIXELS,
    parameter int W      = `CLS_SAMPLE_BITS,
    parameter int IDXW   = `CLS_IDX_BITS
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // Mode and control
    input  wire logic                       halfRes,
    input  wire logic                       transfer,
    // Light input, one sample per pixel
    input  wire logic [PIXELS-1:0][W-1:0]   photoLevel,
    // Read port
    input  wire logic [IDXW-1:0]            readIdx,
    output logic      [W:0]                 heldLevel
);

    ////////////////////////////////////////////////////////////////////////
    logic [W:0] held [PIXELS];

    for (genvar g = 0; g < PIXELS; g++) begin : g_pixel
        logic [W:0]   acc;
        wire  logic   pairLead = ((g % 2) == 0) && (g + 1 < PIXELS);
        // Second pixel of a pair sleeps in half resolution
        wire  logic   active   = !(halfRes && !pairLead);
        wire  logic [W-1:0] partner = (halfRes && pairLead) ?
                                      photoLevel[(g + 1) % PIXELS] : '0;
        wire  logic [W+1:0] sum = {1'b0, acc} + {2'b00, photoLevel[g]} + {2'b00, partner};
        // Saturate rather than wrap: a bright pixel must not read dark
        wire  logic [W:0]   sat = sum[W+1] ? '1 : sum[W:0];

        always_ff @(posedge clock) begin
            if (rst || transfer || !active) begin
                acc <= '0;
            end else begin
                acc <= sat;
            end
        end

        always_ff @(posedge clock) begin
            if (rst) begin
                held[g] <= '0;
            end else if (transfer) begin
                held[g] <= acc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Out-of-range index reads zero
    assign heldLevel = (readIdx < IDXW'(PIXELS)) ? held[readIdx] : '0;

endmodule

// file: hw/cls_scan.sv
/*
 * Scan control of one cascadable linear image-sensor die: global start
 * capture, pre-scan initialisation, self or chained start, end-of-scan
 * handoff, output amplifier gating, resolution selection and sequential
 * pixel shift-out onto the video output.
 * Assumes all inputs synchronous to clock; the global start is sampled on
 * the falling clock edge, everything else on the rising edge.
 */
`include "cls_scan_regs.svh"

// Notes on behaviour
// - Global start captured on falling clock edge
// - 82 initialisation cycles before any readout
// - First die self-starts after 82 cycles
// - Other dies wait for chained start pulse
// - End-of-scan early so next die continues seamlessly
// - High-res end-of-scan at cycle 416
// - Output amplifier powered only while reading
// - Resolution select high means high resolution
// - All 344 pixels, or merged pairs
// - Half resolution disables half the stages
// - Same clock rate in both modes
// - Held line read while integration continues
// - Pixels shifted out one at a time
module cls_scan
    import cls_pkg::*;
#(
    parameter int PIXELS = `CLS_PIXELS,
    parameter int W      = `CLS_SAMPLE_BITS
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // Scan start inputs
    input  wire logic                       globalScanStart,
    input  wire logic                       chainStart,
    // Straps
    input  wire logic                       firstDieSelect,
    input  wire logic                       resolutionSelect,
    // Light input
    input  wire logic [PIXELS-1:0][W-1:0]   photoLevel,
    // Video output
    output logic      [W:0]                 videoOut,
    output logic                            videoValid,
    output logic      [`CLS_IDX_BITS-1:0]   pixelNumber,
    output logic                            ampPowerOn,
    // Cascade output
    output logic                            endOfScan
);

    localparam int IDXW  = `CLS_IDX_BITS;
    localparam int TICKW = `CLS_TICK_BITS;
    localparam int AGEW  = `CLS_AGE_BITS;

    ////////////////////////////////////////////////////////////////////////
    // Global start capture
    logic gsFall;
    logic gsFallPrev;

    // Falling-edge sample gives the controller half a cycle of setup
    always_ff @(negedge clock) begin
        if (rst) begin
            gsFall <= 1'b0;
        end else begin
            gsFall <= globalScanStart;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            gsFallPrev <= 1'b0;
        end else begin
            gsFallPrev <= gsFall;
        end
    end

    wire logic startEdge = gsFall && !gsFallPrev;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    cls_state_e            state;
    logic [TICKW-1:0]      tick;
    logic                  armed;
    logic                  halfRes;
    logic [IDXW-1:0]       outIdx;

    // Mode is frozen per line so a strap change cannot split a scan
    wire logic             modeNow   = startEdge ? !resolutionSelect : halfRes;
    wire logic [IDXW-1:0]  outCount  = halfRes ? IDXW'(PIXELS / 2) : IDXW'(PIXELS);
    wire logic             lastOut   = (outIdx == outCount - 1'b1);
    wire logic             initDone  = (state == CLS_INIT) && (tick == `CLS_INIT_CYCLES);
    wire logic             selfGo    = initDone && firstDieSelect;
    wire logic             chainGo   = (state == CLS_WAIT) && armed
                                       && (tick == `CLS_CHAIN_LEAD);
    wire logic             stepGo    = (state == CLS_READ) && !lastOut;
    wire logic             doLoad    = !startEdge && (selfGo || chainGo || stepGo);
    wire logic [IDXW-1:0]  loadIdx   = (state == CLS_READ) ? outIdx + 1'b1 : '0;
    wire logic [IDXW-1:0]  readIdx   = halfRes ? {loadIdx[IDXW-2:0], 1'b0} : loadIdx;
    wire logic             eosHere   = (loadIdx == outCount - 1'b1 - `CLS_EOS_LEAD);
    wire logic             armNow    = (state == CLS_WAIT) && !armed && chainStart;

    ////////////////////////////////////////////////////////////////////////
    // Next-state decode
    cls_state_e            next_state;
    logic [TICKW-1:0]      next_tick;
    logic                  next_armed;

    always_comb begin
        next_state = state;
        next_tick  = tick;
        next_armed = armed;
        if (startEdge) begin
            next_state = CLS_INIT;
            next_tick  = TICKW'(1);
            next_armed = 1'b0;
        end else begin
            unique case (state)
                CLS_IDLE: begin
                    next_tick = '0;
                end
                CLS_INIT: begin
                    next_tick = tick + 1'b1;
                    if (initDone) begin
                        next_state = firstDieSelect ? CLS_READ : CLS_WAIT;
                        next_tick  = '0;
                    end
                end
                CLS_WAIT: begin
                    if (armNow) begin
                        next_armed = 1'b1;
                        next_tick  = TICKW'(1);
                    end else if (chainGo) begin
                        next_state = CLS_READ;
                        next_armed = 1'b0;
                        next_tick  = '0;
                    end else if (armed) begin
                        next_tick = tick + 1'b1;
                    end
                end
                CLS_READ: begin
                    if (lastOut) begin
                        next_state = CLS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= CLS_IDLE;
            tick  <= '0;
            armed <= 1'b0;
        end else begin
            state <= next_state;
            tick  <= next_tick;
            armed <= next_armed;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            halfRes <= 1'b0;
        end else begin
            halfRes <= modeNow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel store; the line just integrated moves to hold at global start
    logic [W:0] heldLevel;

    cls_pixel_hold #(
        .PIXELS     (PIXELS),
        .W          (W),
        .IDXW       (IDXW)
    ) u_hold (
        .clock      (clock),
        .rst        (rst),
        .halfRes    (modeNow),
        .transfer   (startEdge),
        .photoLevel (photoLevel),
        .readIdx    (readIdx),
        .heldLevel  (heldLevel)
    );

    ////////////////////////////////////////////////////////////////////////
    // Video shift-out, one pixel per clock
    always_ff @(posedge clock) begin
        if (rst || startEdge) begin
            outIdx      <= '0;
            videoOut    <= '0;
            videoValid  <= 1'b0;
            pixelNumber <= '0;
            endOfScan   <= 1'b0;
        end else if (doLoad) begin
            outIdx      <= loadIdx;
            videoOut    <= heldLevel;
            videoValid  <= 1'b1;
            pixelNumber <= loadIdx + 1'b1;
            endOfScan   <= eosHere;
        end else begin
            videoValid  <= (state == CLS_READ) ? 1'b0 : videoValid;
            endOfScan   <= 1'b0;
        end
    end

    // Amplifier only burns power while this die owns the video line
    assign ampPowerOn = videoValid;

    ////////////////////////////////////////////////////////////////////////
    // Line age since global start, saturating
    // Long waits judged on this count, too costly to unroll as delays
    logic [AGEW-1:0]       sinceStart;

    always_ff @(posedge clock) begin
        if (rst) begin
            sinceStart <= '0;
        end else if (startEdge) begin
            sinceStart <= AGEW'(1);
        end else if (sinceStart != '1) begin
            sinceStart <= sinceStart + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_init_quiet: assert property ((state == CLS_INIT) |-> !videoValid && !ampPowerOn)
        else $error("video active during initialisation");

    a_self_start: assert property (startEdge && firstDieSelect
        ##1 (!startEdge)[*8] |-> ##75 (videoValid && pixelNumber == 1))
        else $error("self start pixel 1 not at cycle 83");

    a_self_age: assert property ((sinceStart == `CLS_FIRST_CYCLE) && firstDieSelect
        |-> videoValid && pixelNumber == IDXW'(1))
        else $error("first pixel not at cycle 83");

    a_start_clear: assert property (startEdge |=> !videoValid && !endOfScan)
        else $error("global start did not clear the video line");

    a_chain_hold: assert property ((state == CLS_WAIT) && !armed && !chainStart
        |=> !videoValid)
        else $error("chained die read out without start");

    a_chain_lead: assert property (armNow && !startEdge
        |-> ##11 (videoValid && pixelNumber == 1))
        else $error("chained die pixel 1 late or early");

    a_eos_cycle: assert property ((sinceStart == `CLS_EOS_CYCLE) && firstDieSelect
        && !halfRes |-> endOfScan)
        else $error("end of scan not at cycle 416");

    a_eos_half: assert property ((sinceStart == `CLS_EOS_CYCLE_HALF) && halfRes
        && firstDieSelect |-> endOfScan)
        else $error("half resolution end of scan misplaced");

    a_line_end: assert property ((sinceStart == `CLS_LAST_CYCLE) && !halfRes
        && firstDieSelect |-> videoValid && pixelNumber == IDXW'(PIXELS) ##1 !videoValid)
        else $error("high resolution line length wrong");

    a_half_end: assert property ((sinceStart == `CLS_LAST_CYCLE_HALF) && halfRes
        && firstDieSelect |-> videoValid && pixelNumber == IDXW'(PIXELS / 2) ##1 !videoValid)
        else $error("half resolution line length wrong");

    a_eos_place: assert property (endOfScan |-> videoValid
        && pixelNumber == outCount - `CLS_EOS_LEAD)
        else $error("end of scan not at eleventh from last");

    a_eos_single: assert property (endOfScan |=> !endOfScan)
        else $error("end of scan longer than one cycle");

    a_amp_gate: assert property ((state != CLS_READ) |=> !ampPowerOn || $past(doLoad))
        else $error("amplifier on while not selected");

    a_half_count: assert property (videoValid && halfRes
        |-> pixelNumber <= IDXW'(PIXELS / 2))
        else $error("half resolution output beyond pair count");

    a_pixel_step: assert property (videoValid && $past(videoValid) && !$past(startEdge)
        |-> pixelNumber == $past(pixelNumber) + 1'b1)
        else $error("pixel sequence skipped");

    a_mode_hold: assert property (!startEdge |=> halfRes == $past(halfRes))
        else $error("resolution changed mid line");

    c_self_scan:  cover property (selfGo);
    c_chain_scan: cover property (chainGo);
    c_half_eos:   cover property (endOfScan && halfRes);
    c_full_eos:   cover property (endOfScan && !halfRes);
    c_chain_half: cover property (chainGo && halfRes);

endmodule

// file: dv/cls_ctrl_model.sv
/*
 * Model of the module controller and of the preceding die in the chain:
 * drives the global start and the chained start of the die under test.
 * Assumes the bench calls its tasks 1 ns after a rising clock edge.
 */
module cls_ctrl_model (
    // Pixel clock, one pixel slot per tick
    input  wire logic clock,
    // Start outputs
    output logic      globalScanStart,
    output logic      chainStart
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        globalScanStart = 1'b0;
        chainStart      = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One start pulse, shared by every die of the module
    // Returns 1 ns after the first rising edge that acts on it
    task automatic start_line();
        @(posedge clock);
        #1 globalScanStart = 1'b1;
        @(posedge clock);
        #1 globalScanStart = 1'b0;
    endtask

    // Preceding die's end-of-scan, wired straight to the chained start
    task automatic set_chain(input logic v);
        chainStart = v;
    endtask
endmodule

// file: dv/tb.sv
/*
 * Self-checking bench of the scan block: first and chained die, both
 * resolutions, judged cycle by cycle against the documented timing.
 * Assumes the design package and headers are compiled first.
 */
module tb;
    import cls_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clock = 1'b0;
    logic                  rst   = 1'b1;
    logic                  firstDieSelect   = 1'b1;
    logic                  resolutionSelect = 1'b1;
    logic [343:0][7:0]     photoLevel;
    wire  logic            globalScanStart;
    wire  logic            chainStart;
    logic [8:0]            videoOut;
    logic                  videoValid;
    logic [8:0]            pixelNumber;
    logic                  ampPowerOn;
    logic                  endOfScan;
    int                    miscompares = 0;
    int                    cmpCount    = 0;

    always #2 clock = ~clock;

    cls_ctrl_model ctrl (
        .clock           (clock),
        .globalScanStart (globalScanStart),
        .chainStart      (chainStart)
    );

    cls_scan DUT (
        .clock            (clock),
        .rst              (rst),
        .globalScanStart  (globalScanStart),
        .chainStart       (chainStart),
        .firstDieSelect   (firstDieSelect),
        .resolutionSelect (resolutionSelect),
        .photoLevel       (photoLevel),
        .videoOut         (videoOut),
        .videoValid       (videoValid),
        .pixelNumber      (pixelNumber),
        .ampPowerOn       (ampPowerOn),
        .endOfScan        (endOfScan)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [8:0] seen, input logic [8:0] want);
        cmpCount++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: seen %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        if (miscompares == 0 && cmpCount > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Every third pixel saturates at once, the rest stay dark; in half resolution two of every three pairs saturate
    function automatic logic [8:0] lit(input int k, input logic hi);
        if (hi)
            return (k % 3 == 0) ? 9'h1ff : 9'h000;
        return ((2*k-1) % 3 == 0 || (2*k) % 3 == 0) ? 9'h1ff : 9'h000;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // One line from global start to the end of readout; the first line of a
    // pair only warms up the integrators, so its held values are not judged
    task automatic run_line(input logic first, input logic hi, input logic judge);
        int   e;
        int   k;
        int   n;
        int   st;
        logic win;
        n  = hi ? 344 : 172;
        st = first ? 83 : 160;
        firstDieSelect   = first;
        resolutionSelect = hi;
        ctrl.start_line();
        for (e = 1; e <= st + n + 1; e++) begin
            k   = e - st + 1;
            win = (k >= 1 && k <= n);
            if (judge) begin
                chk(9'(videoValid), 9'(win));
                chk(9'(ampPowerOn), 9'(win));
                chk(9'(endOfScan), 9'(k == n - 10));
                if (win) begin
                    chk(pixelNumber, 9'(k));
                    chk(videoOut, lit(k, hi));
                end
            end
            ctrl.set_chain(!first && e == 149);
            @(posedge clock);
            #1;
        end
    endtask

    task automatic scen_high_first();
        run_line(1'b1, 1'b1, 1'b0);
        run_line(1'b1, 1'b1, 1'b1);
    endtask

    task automatic scen_half_first();
        run_line(1'b1, 1'b0, 1'b0);
        run_line(1'b1, 1'b0, 1'b1);
    endtask

    // Chained die must stay dark where a first die would start reading, until pixel 1 at cycle 160
    task automatic scen_chained();
        run_line(1'b0, 1'b1, 1'b0);
        run_line(1'b0, 1'b1, 1'b1);
        run_line(1'b0, 1'b0, 1'b0);
        run_line(1'b0, 1'b0, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 344; i++)
            photoLevel[i] = ((i + 1) % 3 == 0) ? 8'hff : 8'h00;
        repeat (20) @(posedge clock);
        #1 rst = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        scen_high_first();
        scen_half_first();
        scen_chained();
        wrap_up();
    end

    // Hang guard: far beyond the few thousand cycles the run needs
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
endmodule
